// *** common/adcp_consts.svh ***
// Constants for the parallel conversion port: offsets, fields, timing.
// Assumes inclusion by bare name from the package and the design files.
`ifndef ADCP_CONSTS_SVH
`define ADCP_CONSTS_SVH

// Register byte offsets on the APB
`define ADCP_OFF_CTRL     12'h000
`define ADCP_OFF_STATUS   12'h004
`define ADCP_OFF_RESULT   12'h008
`define ADCP_OFF_IRQ_STAT 12'h00C
`define ADCP_OFF_IRQ_MASK 12'h010

// Field positions
`define ADCP_CTRL_EN      0
`define ADCP_ST_BUSY      0
`define ADCP_ST_FIRST     1
`define ADCP_ST_DRIVE     2
`define ADCP_IRQ_DONE     0
`define ADCP_IRQ_OVR      1
`define ADCP_IRQ_W        2

// Reset values
`define ADCP_CTRL_RST     1'h1
`define ADCP_MASK_RST     2'h0
`define ADCP_RES_RST      16'h0000

// Result layout
`define ADCP_RES_W        16
`define ADCP_HALF         8

// Timing
`define ADCP_CLK_NS       4
`define ADCP_BUSY_MAX_NS  83
`define ADCP_BUSY_MAX_CYC (`ADCP_BUSY_MAX_NS / `ADCP_CLK_NS)
`define ADCP_SYNC_CYC     2
`define ADCP_CONV_NS      4000
`define ADCP_CONV_CYC     (`ADCP_CONV_NS / `ADCP_CLK_NS)

`endif

// *** common/adcp_pkg.sv ***
// Types shared by the parallel conversion port design files.
// Assumes adcp_consts.svh is on the include path.
`include "adcp_consts.svh"

package adcp_pkg;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_STORE,
    ST_SHOW
  } adcp_state_e;

  // Control pins as seen after synchronising
  typedef struct packed {
    logic sel_n;
    logic read_conv;
    logic half_swap;
  } adcp_pins_s;

endpackage

// *** src/adcp_result_reg.sv ***
// Output result register of the conversion port.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`include "adcp_consts.svh"

module adcp_result_reg
  import adcp_pkg::*;
#(
  parameter int W = `ADCP_RES_W
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_wr_en,
  input  wire logic [W-1:0] i_wr_data,
  output logic      [W-1:0] o_rd_data
);

  // Latch a finished result, read data straight from the flop
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data <= `ADCP_RES_RST;
    end else if (i_wr_en) begin
      o_rd_data <= i_wr_data;
    end
  end

endmodule // adcp_result_reg

// *** src/adcp_port.sv ***
// Conversion control and parallel result port of a 16-bit sampling ADC.
// Assumes host pins are asynchronous; the quantiser code is on i_sys_clk.
//
// Overview of operation
// (R01) Result is a 16-bit word, bit 15 most significant, bit 0 least.
// (R02) Data pins float while select is high or read/convert is low.
// (R03) Half-swap high exchanges the upper and lower 8 result bits.
// (R04) With select low, read/convert falling holds the sample and converts.
// (R05) With select low, read/convert rising enables the data pins.
// (R06) Select and read/convert are ORed; select falling converts if R/C low.
// (R07) With read/convert high, select falling enables the data pins.
// (R08) Busy goes low at start, stays low until result is latched.
// (R09) Result is valid on the pins when busy returns high.
// (R10) Host may latch the result on the rising edge of busy.
// (R11) Host holds select and read/convert low together at least 50 ns.
// (R12) Busy falls less than 83 ns after a conversion starts.
// (R13) Results are coded in two's complement.
// (R14) First result after power-up is indeterminate; host discards it.
// (R15) Host never requests a conversion while busy is low; the testbench does once, which sets the overrun flag.
`timescale 1ns/1ps
`include "adcp_consts.svh"

module adcp_port
  import adcp_pkg::*;
#(
  parameter int CONV_CYCLES = `ADCP_CONV_CYC,
  parameter int AW          = 12
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_reset_n,
  // Host pins
  input  wire logic            i_sel_n,
  input  wire logic            i_read_conv,
  input  wire logic            i_half_swap,
  output logic                 o_busy_n,
  output logic [15:0]          o_data_q,
  output logic [15:0]          o_data_oe_n,
  // Offset-binary code from the quantiser
  input  wire logic [15:0]     i_sample_code,
  // APB slave
  input  wire logic            i_psel,
  input  wire logic            i_penable,
  input  wire logic            i_pwrite,
  input  wire logic [AW-1:0]   i_paddr,
  input  wire logic [31:0]     i_pwdata,
  output logic [31:0]          o_prdata,
  output logic                 o_pready,
  output logic                 o_pslverr,
  output logic                 o_irq
);

  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam int W  = `ADCP_RES_W;
  localparam int H  = `ADCP_HALF;
  localparam int IW = `ADCP_IRQ_W;
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

  adcp_pins_s  sync1_q;
  adcp_pins_s  sync2_q;
  logic        comb_prev_q;
  adcp_state_e state_q;
  adcp_state_e state_d;
  logic [CW-1:0] cnt_q;
  logic [W-1:0]  hold_q;
  logic        busy_n_q;
  logic        first_q;
  logic        en_q;
  logic [IW-1:0] stat_q;
  logic [IW-1:0] mask_q;
  logic [31:0] prdata_q;
  logic [15:0] data_q;
  logic [15:0] oe_n_q;
  logic [W-1:0] res_q;

  // Two-flop synchroniser on the host pins
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= '{i_sel_n, i_read_conv, i_half_swap};
      sync2_q <= sync1_q;
    end
  end

  // Pin decode after synchronising
  wire sel_s  = sync2_q.sel_n;
  wire rc_s   = sync2_q.read_conv;
  wire swap_s = sync2_q.half_swap;
  wire comb_s = sel_s | rc_s;                  // see (R06)
  wire drive  = ~sel_s & rc_s;                 // see (R05) (R07)

  // Previous level of the ORed start line
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      comb_prev_q <= 1'b1;
    end else begin
      comb_prev_q <= comb_s;
    end
  end

  // Start request: ORed line falls, from either pin
  wire start_req = comb_prev_q & ~comb_s;      // see (R04) (R06)
  wire idle      = (state_q == ST_IDLE);
  wire start_ok  = start_req & idle & en_q;
  wire overrun   = start_req & ~idle;
  wire cnt_end   = (cnt_q == '0);
  wire res_we    = (state_q == ST_STORE);
  wire done_evt  = (state_q == ST_SHOW);

  // Offset binary to two's complement by flipping the sign bit
  wire [W-1:0] conv_word = {~hold_q[W-1], hold_q[W-2:0]}; // see (R13)

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_ok) begin
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (cnt_end) begin
          state_d = ST_STORE;
        end
      end
      ST_STORE: begin
        state_d = ST_SHOW;
      end
      ST_SHOW: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Conversion timer and sample hold
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q  <= '0;
      hold_q <= '0;
    end else if (start_ok) begin
      cnt_q  <= CONV_LAST;
      hold_q <= i_sample_code;                 // see (R04)
    end else if (!cnt_end) begin
      cnt_q  <= cnt_q - 1'b1;
    end
  end

  // Busy low from start until the shown result reaches the pins
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_n_q <= 1'b1;
    end else if (start_ok) begin
      busy_n_q <= 1'b0;                        // see (R08) (R12)
    end else if (done_evt) begin
      busy_n_q <= 1'b1;                        // see (R08) (R09)
    end
  end

  // Flags the first conversion after reset; clears as its result is shown
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      first_q <= 1'b1;
    end else if (done_evt) begin
      first_q <= 1'b0;                         // see (R14)
    end
  end

  // Output result register
  adcp_result_reg #(
    .W (W)
  ) u_result (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_wr_en   (res_we),
    .i_wr_data (conv_word),
    .o_rd_data (res_q)
  );

  // Pin order, natural or with halves exchanged
  logic [15:0] pin_word;
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_pin
      assign pin_word[gi] = swap_s ? res_q[(gi + H) % W] : res_q[gi]; // see (R01) (R03)
    end
  endgenerate

  // Data pins and their enables from flops
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_q <= '0;
      oe_n_q <= '1;
    end else begin
      data_q <= pin_word;
      oe_n_q <= {W{~drive}};                   // see (R02) (R05) (R07)
    end
  end

  assign o_busy_n    = busy_n_q;
  assign o_data_q    = data_q;
  assign o_data_oe_n = oe_n_q;

  // APB decode
  wire setup    = i_psel & ~i_penable;
  wire access   = i_psel & i_penable;
  wire hit_ctrl = (i_paddr == `ADCP_OFF_CTRL);
  wire hit_stat = (i_paddr == `ADCP_OFF_STATUS);
  wire hit_res  = (i_paddr == `ADCP_OFF_RESULT);
  wire hit_ist  = (i_paddr == `ADCP_OFF_IRQ_STAT);
  wire hit_imk  = (i_paddr == `ADCP_OFF_IRQ_MASK);
  wire mapped   = hit_ctrl | hit_stat | hit_res | hit_ist | hit_imk;
  wire wr_ctrl  = access & i_pwrite & hit_ctrl;
  wire wr_ist   = access & i_pwrite & hit_ist;
  wire wr_imk   = access & i_pwrite & hit_imk;

  // Status word of the sequencer
  wire [31:0] status_w = {29'h0000_0000, drive, first_q, ~busy_n_q};

  // Read selection
  wire [31:0] rd_mux =
    hit_ctrl ? {31'h0000_0000, en_q} :
    hit_stat ? status_w :
    hit_res  ? {16'h0000, res_q} :
    hit_ist  ? {{(32-IW){1'b0}}, stat_q} :
    hit_imk  ? {{(32-IW){1'b0}}, mask_q} :
    32'h0000_0000;

  // Read data captured in the setup phase
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prdata_q <= '0;
    end else if (setup & ~i_pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  assign o_prdata  = prdata_q;
  assign o_pready  = 1'b1;
  assign o_pslverr = access & ~mapped;

  // Control and mask registers
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_q   <= `ADCP_CTRL_RST;
      mask_q <= `ADCP_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        en_q <= i_pwdata[`ADCP_CTRL_EN];
      end
      if (wr_imk) begin
        mask_q <= i_pwdata[IW-1:0];
      end
    end
  end

  // Sticky events, write one to clear, a new event wins
  wire [IW-1:0] evt = {overrun, done_evt};
  wire [IW-1:0] clr = wr_ist ? i_pwdata[IW-1:0] : '0;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr) | evt;
    end
  end

  assign o_irq = |(stat_q & mask_q);

  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  localparam int BUSY_CYC = `ADCP_BUSY_MAX_CYC - `ADCP_SYNC_CYC;
  wire [15:0] res_swapped = {res_q[H-1:0], res_q[W-1:H]};
  wire [15:0] pin_expect  = swap_s ? res_swapped : res_q;
  wire sign_ok = (res_q[W-1] == ~hold_q[W-1]);

  sequence s_start;
    start_ok;
  endsequence

  sequence s_busy_low;
    (!o_busy_n) [*8];
  endsequence

  a_busy_fall_soon: assert property (s_start |-> ##[1:BUSY_CYC] !o_busy_n) // see (R12)
    else $error("busy did not fall in time after a start");

  a_busy_stays_low: assert property (s_start |=> s_busy_low) // see (R08)
    else $error("busy rose too early during conversion");

  a_data_at_busy: assert property ($rose(o_busy_n) |-> o_data_q == $past(pin_expect)) // see (R09)
    else $error("result not on pins when busy rose");

  a_natural_order: assert property (!swap_s |=> o_data_q == $past(res_q)) // see (R01)
    else $error("pins not in natural order");

  a_half_swap: assert property (swap_s |=> o_data_q == $past(res_swapped)) // see (R03)
    else $error("halves not exchanged");

  a_float_off: assert property (!drive |=> &o_data_oe_n) // see (R02)
    else $error("data pins driven while deselected");

  a_drive_on: assert property (drive |=> !(|o_data_oe_n)) // see (R05)
    else $error("data pins not driven while read");

  a_twos_comp: assert property (res_we |=> sign_ok) // see (R13)
    else $error("result sign not converted");

  a_first_clear: assert property ($rose(o_busy_n) |-> !first_q && stat_q[`ADCP_IRQ_DONE]) // see (R14)
    else $error("first flag or done flag wrong at end");

  // Sample is frozen at the start edge
  a_hold_sample: assert property (s_start |=> hold_q == $past(i_sample_code)) // see (R04)
    else $error("sample not held at conversion start");

  // Busy may only rise out of the show step
  a_busy_end_done: assert property ($rose(o_busy_n) |-> $past(done_evt)) // see (R08)
    else $error("busy rose before the result was latched");

  // Store, then show, then busy high on the cycle after the show step
  sequence s_store_show;
    res_we ##1 done_evt;
  endsequence

  a_store_show: assert property (res_we |-> s_store_show ##1 o_busy_n) // see (R09)
    else $error("store and show steps out of order");

  // A start while disabled leaves the sequencer idle and busy high
  a_start_refused: assert property (start_req && idle && !en_q |=> idle && o_busy_n) // see (R08)
    else $error("start accepted while disabled");

endmodule // adcp_port

// *** dv/adcp_host_model.sv ***
// Host model: drives select and read/convert, latches the result word.
// Assumes the port's clock; pins change by NBA right after rising edges.
`timescale 1ns/1ps

module adcp_host_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_busy_n,
  input  wire logic [15:0] i_data_q,
  input  wire logic [15:0] i_data_oe_n,
  output logic             o_sel_n,
  output logic             o_read_conv,
  output logic [15:0]      o_word,
  output logic [15:0]      o_oe_conv,
  output int               o_fall_cyc
);
  logic [15:0] last_q = 16'h0000;
  wire  [15:0] bus    = (i_data_oe_n == 16'h0000) ? i_data_q : ~last_q;

  // Pins idle high until the first request
  initial begin
    o_sel_n     = 1'b1;
    o_read_conv = 1'b1;
  end

  // A released bus shows the inverse of its last driven value
  always @(posedge i_sys_clk) begin
    if (i_data_oe_n == 16'h0000) last_q <= i_data_q;
  end

  // One conversion; by_sel starts with select, again retriggers while busy
  task automatic convert(input bit by_sel, input bit again);
    int w;
    o_fall_cyc = 0;
    @(posedge i_sys_clk);
    if (by_sel) o_read_conv <= 1'b0;
    else o_sel_n <= 1'b0;
    @(posedge i_sys_clk);
    if (by_sel) o_sel_n <= 1'b0;
    else o_read_conv <= 1'b0;
    // Both low for 13 cycles, over 50 ns
    for (int i = 1; i <= 13; i++) begin
      @(negedge i_sys_clk);
      if (!i_busy_n && o_fall_cyc == 0) o_fall_cyc = i;
    end
    o_oe_conv = i_data_oe_n;
    @(posedge i_sys_clk);
    o_read_conv <= 1'b1;
    if (by_sel) o_sel_n <= 1'b1;
    if (again) begin
      repeat (3) @(posedge i_sys_clk);
      o_read_conv <= 1'b0;
      repeat (13) @(posedge i_sys_clk);
      o_read_conv <= 1'b1;
    end
    w = 0;
    while (!i_busy_n && w < 300) begin
      @(negedge i_sys_clk);
      w++;
    end
    if (by_sel) begin
      @(posedge i_sys_clk);
      o_sel_n <= 1'b0;
      repeat (5) @(negedge i_sys_clk);
    end
    o_word = bus;
    @(posedge i_sys_clk);
    o_sel_n <= 1'b1;
  endtask
endmodule // adcp_host_model

// *** dv/testbench.sv ***
// Testbench: host pins, quantiser code and APB traffic for the port.
// Assumes adcp_consts.svh on the include path and the host model file.
`timescale 1ns/1ps
`include "adcp_consts.svh"

module testbench;
  logic        clk, rst_n, half_swap, psel, penable, pwrite, pready, pslverr, irq;
  logic        busy_n, sel_n, rc;
  logic [15:0] code, data_q, oe_n, word, oe_conv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int          fall_cyc, num_errors, n_compared;
  logic [15:0] corner [3] = '{16'h0000, 16'hFFFF, 16'h8001};

  adcp_port #(.CONV_CYCLES(40)) dut (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_sel_n(sel_n), .i_read_conv(rc),
    .i_half_swap(half_swap), .o_busy_n(busy_n), .o_data_q(data_q),
    .o_data_oe_n(oe_n), .i_sample_code(code), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq));

  adcp_host_model host (
    .i_sys_clk(clk), .i_busy_n(busy_n), .i_data_q(data_q), .i_data_oe_n(oe_n),
    .o_sel_n(sel_n), .o_read_conv(rc), .o_word(word), .o_oe_conv(oe_conv),
    .o_fall_cyc(fall_cyc));

  // Clock at 250 MHz
  always #2 clk = ~clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    check(q, exp);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  // Two's complement of the offset code, halves exchanged on request
  function automatic logic [15:0] exp_word(input logic [15:0] c, input logic sw);
    logic [15:0] t;
    t = c ^ 16'h8000;
    return sw ? {t[7:0], t[15:8]} : t;
  endfunction

  task automatic give_verdict();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end

  // Main sequence
  initial begin
    logic [31:0] q;
    logic        e;
    {clk, rst_n, half_swap, psel, penable, pwrite} = 6'b000000;
    code = 16'h0000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    num_errors = 0;
    n_compared = 0;
    void'($urandom(32'h2e32));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(busy_n, 1'b1);
    check(oe_n, 16'hFFFF);
    rd(`ADCP_OFF_STATUS, 32'h0000_0002);
    rd(`ADCP_OFF_IRQ_MASK, 32'h0000_0000);
    rd(`ADCP_OFF_CTRL, 32'h0000_0001);
    apb(1'b0, 12'h0F0, 32'h0000_0000, q, e);
    check({q[30:0], e}, 32'h0000_0001);
    for (int k = 0; k < 10; k++) begin
      code <= (k < 3) ? corner[k] : 16'($urandom());
      half_swap <= 1'($urandom());
      repeat (4) @(posedge clk);
      host.convert(k[0], k == 2);
      check(busy_n, 1'b1);
      check(word, exp_word(code, half_swap));
      check(fall_cyc != 0, 1'b1);
      check(oe_conv, 16'hFFFF);
      repeat (4) @(negedge clk);
      check(oe_n, 16'hFFFF);
      rd(`ADCP_OFF_RESULT, {16'h0000, code ^ 16'h8000});
      if (k == 0) rd(`ADCP_OFF_STATUS, 32'h0000_0000);
    end
    // A start while disabled is ignored and leaves the result alone
    wr(`ADCP_OFF_CTRL, 32'h0000_0000);
    rd(`ADCP_OFF_CTRL, 32'h0000_0000);
    host.convert(1'b0, 1'b0);
    check(fall_cyc, 32'h0000_0000);
    check(busy_n, 1'b1);
    rd(`ADCP_OFF_RESULT, {16'h0000, code ^ 16'h8000});
    wr(`ADCP_OFF_CTRL, 32'h0000_0001);
    rd(`ADCP_OFF_CTRL, 32'h0000_0001);
    rd(`ADCP_OFF_IRQ_STAT, 32'h0000_0003);
    check(irq, 1'b0);
    wr(`ADCP_OFF_IRQ_MASK, 32'h0000_0001);
    @(negedge clk);
    check(irq, 1'b1);
    wr(`ADCP_OFF_IRQ_STAT, 32'h0000_0003);
    @(negedge clk);
    check(irq, 1'b0);
    rd(`ADCP_OFF_IRQ_STAT, 32'h0000_0000);
    give_verdict();
  end
endmodule // testbench
